// [testbench/srer_media_model.sv]
// srer_media_model: media engine partner answering a running command.
// assumes tb sets mode, dly and lba before the command starts.
`timescale 1ns/1ps
module srer_media_model (
  // clock
  input wire logic pclk,
  // busy from srer_top, control from tb
  input wire logic busy,
  input wire logic [2:0] mode,
  input wire logic [3:0] dly,
  input wire logic [47:0] lba,
  // media engine
  output logic media_done,
  output logic fail_valid,
  output srer_pkg::srer_fail_t fail_info
);
  initial begin
    media_done = 1'b0;
    fail_valid = 1'b0;
    fail_info = '0;
  end
  // mode 1..3 fail kind, 4 stalls forever so only the limit ends it
  always @(posedge busy) begin
    repeat (dly + 1) @(posedge pclk);
    if (mode != 3'h0 && mode != 3'h4) begin
      fail_valid <= 1'b1;
      fail_info <= {mode == 3'h1, mode == 3'h2, mode == 3'h3, lba, lba[15:0]};
      @(posedge pclk);
      fail_valid <= 1'b0;
      // stale data would hide a late capture
      fail_info <= ~fail_info;
    end
    if (mode != 3'h4) begin
      @(posedge pclk);
      media_done <= 1'b1;
      @(posedge pclk);
      media_done <= 1'b0;
    end
  end
endmodule // srer_media_model

// [testbench/srer_top_assertions.sv]
// srer_top_assertions: port checks of srer_top.
// assumes one pclk domain; bound below.
`timescale 1ns/1ps
module srer_chk (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // media and state
  input wire logic media_done,
  input wire logic busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic setup = psel && !penable;
  wire logic cmd = setup && pwrite && paddr == 8'h04 && !busy;
  chk_ready_next: assert property (setup |=> pready) else $error("no ready");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("long");
  chk_err_ready: assert property (pslverr |-> pready) else $error("lone err");
  chk_err_map: assert property (setup && paddr > 8'h24 |=> pslverr)
    else $error("no slverr");
  chk_err_data: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("err data");
  chk_busy_start: assert property (cmd |=> ##1 busy) else $error("no busy");
  chk_busy_cause: assert property ($rose(busy) |-> $past(cmd, 2))
    else $error("busy uncaused");
  chk_busy_end: assert property (busy && media_done |=> !busy)
    else $error("busy stuck");
endmodule // srer_chk
bind srer_top srer_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .media_done, .busy);

// [testbench/tb.sv]
// tb: apb bench for srer_top with a media model; queued read checks.
// assumes the register map of srer_pkg and a 20 MHz pclk.
`timescale 1ns/1ps
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, media_done, fail_valid, irq, busy;
  srer_pkg::srer_fail_t fail_info;
  logic [2:0] mode = '0;
  logic [3:0] dly = '0;
  logic [47:0] lba = '0;
  logic [63:0] q[$];
  int n_errors = 0, num_checks = 0;
  always #25 pclk = ~pclk;
  srer_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .media_done, .fail_valid, .fail_info, .irq,
    .busy);
  srer_media_model u_media (.pclk, .busy, .mode, .dly, .lba, .media_done,
    .fail_valid, .fail_info);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // oldest note is {expected, mask}
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      chk(prdata & q[0][31:0], q[0][63:32]);
      void'(q.pop_front());
    end
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m = '1);
    q.push_back({e, m});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic run(logic [7:0] lim, logic rc, logic [2:0] md);
    mode <= md;
    dly <= 4'($urandom);
    lba <= 48'({$urandom, $urandom});
    bus(1'b1, srer_pkg::OFF_CMD, {15'h0, rc, 8'h0, lim});
    repeat (2) @(posedge pclk);
    while (busy !== 1'b0) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask
  task automatic fchk;
    rd(srer_pkg::OFF_FAIL, {lba[23:0], lba[7:0]});
    bus(1'b1, srer_pkg::OFF_CTRL, 32'h1);
    rd(srer_pkg::OFF_FAIL, {lba[47:24], lba[15:8]});
    bus(1'b1, srer_pkg::OFF_CTRL, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    n_errors++;
    results();
  end
  initial begin
    logic [7:0] e;
    void'($urandom(92));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(srer_pkg::OFF_TASK, 32'h40, 32'hFFFF);
    bus(1'b1, srer_pkg::OFF_IRQ_MSK, 32'h2);
    for (int m = 1; m < 4; m++)
      for (int rc = 0; rc < 2; rc++) begin
        e = 8'h40 >> (2 * m - 2);
        run(8'h0, rc[0], 3'(m));
        fchk();
        if (rc == 0) begin
          chk(irq, 32'h1);
          rd(srer_pkg::OFF_IRQ_ST, 32'h2, 32'h2);
          repeat (2) @(posedge pclk);
          chk(irq, 32'h0);
          rd(srer_pkg::OFF_TASK, {16'h0, e, 8'h41}, 32'hFFE1);
        end else begin
          rd(srer_pkg::OFF_TASK, 32'h60, 32'hFFE1);
          rd(srer_pkg::OFF_ELOG, {24'h0, e}, {24'h0, e});
        end
      end
    bus(1'b1, srer_pkg::OFF_TASK, 32'h1);
    bus(1'b1, srer_pkg::OFF_CFG, 32'h0);
    run(8'h2, 1'b0, 3'h4);
    rd(srer_pkg::OFF_TASK, 32'h0141, 32'hFFE1);
    bus(1'b1, srer_pkg::OFF_CFG, 32'h1);
    run(8'h0, 1'b1, 3'h4);
    rd(srer_pkg::OFF_TASK, 32'h0060, 32'hFFE1);
    rd(srer_pkg::OFF_ELOG, 32'h1, 32'h1);
    bus(1'b1, srer_pkg::OFF_CFG, 32'h0);
    run(8'h0, 1'b0, 3'h0);
    rd(srer_pkg::OFF_TASK, 32'h0040, 32'hFFE1);
    rd(8'h28, 32'h0);
    repeat (2) @(posedge pclk);
    results();
  end
endmodule // tb

// [verilog/srer_pkg.sv]
// srer_pkg: register map, field positions and types of the stream read
// error reporting block; assumes a 32-bit apb master on pclk.
package srer_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_LBA_LO = 8'h08;
  localparam logic [7:0] OFF_LBA_HI = 8'h0C;
  localparam logic [7:0] OFF_FAIL = 8'h10;
  localparam logic [7:0] OFF_TASK = 8'h14;
  localparam logic [7:0] OFF_ELOG = 8'h18;
  localparam logic [7:0] OFF_IRQ_ST = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h20;
  localparam logic [7:0] OFF_CFG = 8'h24;
  // error register bit positions
  localparam int ERR_COMPLETION_DEADLINE_OVERRUN = 0;
  localparam int ERR_ABT = 2;
  localparam int ERR_IDN = 4;
  localparam int ERR_UNC = 6;
  // status register bit positions
  localparam int ST_ERR = 0;
  localparam int ST_SE = 5;
  localparam int ST_RDY = 6;
  localparam int ST_BSY = 7;
  // ctrl register bit positions
  localparam int CTRL_HOB = 0;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_SE = 2;
  // reset values
  localparam logic [7:0] STATUS_RST = 8'h40;
  localparam logic [31:0] UNIT_US_RST = 32'h0000_0001;
  // time base: one microsecond at the 20 MHz pclk
  localparam int CLK_MHZ = 20;
  localparam int CYC_PER_US = CLK_MHZ;

  // failure report from the media engine
  typedef struct packed {
    logic unc;
    logic idnf;
    logic abrt;
    logic [47:0] lba;
    logic [15:0] count;
  } srer_fail_t;

  typedef enum logic [1:0] {S_IDLE, S_RUN, S_DONE} srer_state_t;
endpackage

// [verilog/srer_top.sv]
// srer_top: result reporting for the extended stream read command.
// assumes an apb master on pclk and a media engine in the same domain
// that pulses fail_valid / media_done while a command runs.
`timescale 1ns/1ps

// Functional notes
// - sector number reads lba 7:0 of the first failure, or 31:24 with hob.
// - cylinder low reads lba 15:8, or 39:32 with hob.
// - cylinder high reads lba 23:16 with hob clear.
// - cylinder high reads lba 47:40 with hob set.
// - error bit 0 is set when the command runs past its time limit.
// - status bit 5 is set on an error when continue-on-error was requested.
// - with that flag the failing lba and suspect sector count are reported.
// - continue-on-error errors set the stream flag and clear error status.
// - in that case the error bits go to the error log instead.
// - the limit is the low command byte (7:0) times a unit in microseconds.
// - a zero limit uses the stream default; a zero default disables it.
module srer_top (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // media engine
  input wire logic media_done,
  input wire logic fail_valid,
  input wire srer_pkg::srer_fail_t fail_info,
  // interrupt and state
  output logic irq,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////
  srer_pkg::srer_state_t state_q;
  logic hob_q;
  logic [7:0] feat_prev_q;
  logic cont_q;
  logic [7:0] dflt_q;
  logic [31:0] unit_us_q;
  logic [47:0] lba_q;
  logic [15:0] cnt_q;
  logic [7:0] err_q;
  logic [7:0] status_q;
  logic [7:0] elog_q;
  logic have_fail_q;
  logic [2:0] irq_st_q;
  logic [2:0] irq_msk_q;
  logic [39:0] limit_q;
  logic [39:0] tcnt_q;
  logic [4:0] us_div_q;
  logic wr;
  logic rd;
  logic start;
  logic overrun;
  logic [7:0] eff_lim;
  logic [2:0] ev;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign start = wr && paddr == srer_pkg::OFF_CMD &&
                 state_q != srer_pkg::S_RUN;

  // time limit of zero falls back to the stream default
  assign eff_lim = (pwdata[7:0] != 8'h00) ? pwdata[7:0] : dflt_q;

  // lba byte picked by hob; keeps the register view in one place
  function automatic logic [7:0] lba_byte(input logic [47:0] lba,
                                          input logic high_order_byte_select, input int lo);
    lba_byte = high_order_byte_select ? lba[lo*8+24 +: 8] : lba[lo*8 +: 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // configuration written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hob_q <= 1'b0;
      dflt_q <= 8'h00;
      unit_us_q <= srer_pkg::UNIT_US_RST;
      irq_msk_q <= 3'h0;
    end else if (wr) begin
      if (paddr == srer_pkg::OFF_CTRL) begin
        hob_q <= pwdata[srer_pkg::CTRL_HOB];
      end
      if (paddr == srer_pkg::OFF_CFG) begin
        dflt_q <= pwdata[7:0];
      end
      if (paddr == srer_pkg::OFF_TASK) begin
        unit_us_q <= pwdata;
      end
      if (paddr == srer_pkg::OFF_IRQ_MSK) begin
        irq_msk_q <= pwdata[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command state and completion timer
  assign overrun = state_q == srer_pkg::S_RUN && limit_q != 40'h0 &&
                   tcnt_q >= limit_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= srer_pkg::S_IDLE;
      feat_prev_q <= 8'h00;
      cont_q <= 1'b0;
      limit_q <= 40'h0;
      tcnt_q <= 40'h0;
      us_div_q <= 5'h0;
    end else if (start) begin
      state_q <= srer_pkg::S_RUN;
      feat_prev_q <= pwdata[15:8];
      cont_q <= pwdata[16];
      // limit in microseconds; zero means no limit
      limit_q <= 40'(eff_lim * unit_us_q);
      tcnt_q <= 40'h0;
      us_div_q <= 5'h0;
    end else if (state_q == srer_pkg::S_RUN) begin
      if (us_div_q == 5'(srer_pkg::CYC_PER_US - 1)) begin
        us_div_q <= 5'h0;
        tcnt_q <= tcnt_q + 40'h1;
      end else begin
        us_div_q <= us_div_q + 5'h1;
      end
      if (media_done || overrun) begin
        state_q <= srer_pkg::S_DONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // first failure capture and result registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lba_q <= 48'h0;
      cnt_q <= 16'h0;
      have_fail_q <= 1'b0;
      err_q <= 8'h00;
      elog_q <= 8'h00;
      status_q <= srer_pkg::STATUS_RST;
    end else if (start) begin
      have_fail_q <= 1'b0;
      err_q <= 8'h00;
      status_q <= 8'h80;
    end else if (state_q == srer_pkg::S_RUN) begin
      // only the first failing sector is kept
      if (fail_valid && !have_fail_q) begin
        lba_q <= fail_info.lba;
        cnt_q <= fail_info.count;
        have_fail_q <= 1'b1;
      end
      if (fail_valid) begin
        err_q[srer_pkg::ERR_UNC] <= err_q[srer_pkg::ERR_UNC] | fail_info.unc;
        err_q[srer_pkg::ERR_IDN] <= err_q[srer_pkg::ERR_IDN] | fail_info.idnf;
        err_q[srer_pkg::ERR_ABT] <= err_q[srer_pkg::ERR_ABT] | fail_info.abrt;
      end
      if (overrun) begin
        err_q[srer_pkg::ERR_COMPLETION_DEADLINE_OVERRUN] <= 1'b1;
      end
      if (media_done || overrun) begin
        status_q[srer_pkg::ST_BSY] <= 1'b0;
        status_q[srer_pkg::ST_RDY] <= 1'b1;
        if ((fail_valid || overrun || have_fail_q) && cont_q) begin
          status_q[srer_pkg::ST_SE] <= 1'b1;
          status_q[srer_pkg::ST_ERR] <= 1'b0;
        end else if (fail_valid || overrun || have_fail_q) begin
          status_q[srer_pkg::ST_ERR] <= 1'b1;
        end
      end
    end else if (state_q == srer_pkg::S_DONE && cont_q &&
                 status_q[srer_pkg::ST_SE] && err_q != 8'h00) begin
      // move once only: a second pass would overwrite the log with zero
      // error bits move to the log; register shows none
      elog_q <= err_q;
      err_q <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status: set wins over the read clear
  assign ev[srer_pkg::IRQ_DONE] = state_q == srer_pkg::S_RUN &&
                                  (media_done || overrun);
  assign ev[srer_pkg::IRQ_ERR] = ev[srer_pkg::IRQ_DONE] &&
                                 (fail_valid || overrun || have_fail_q);
  assign ev[srer_pkg::IRQ_SE] = ev[srer_pkg::IRQ_ERR] && cont_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q <= 3'h0;
    end else if (rd && paddr == srer_pkg::OFF_IRQ_ST) begin
      irq_st_q <= ev;
    end else begin
      irq_st_q <= irq_st_q | ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      busy <= 1'b0;
    end else begin
      irq <= |((irq_st_q | ev) & irq_msk_q);
      busy <= (state_q == srer_pkg::S_RUN && !(media_done || overrun)) ||
              start;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb answer: decoded in the setup phase, so no wait state and all outputs are flopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      unique case (paddr)
        srer_pkg::OFF_CTRL: prdata <= {31'h0, hob_q};
        srer_pkg::OFF_CMD: prdata <= {15'h0, cont_q, feat_prev_q, 8'h00};
        srer_pkg::OFF_LBA_LO: prdata <= lba_q[31:0];
        srer_pkg::OFF_LBA_HI: prdata <= {16'h0, lba_q[47:32]};
        srer_pkg::OFF_FAIL: prdata <= {
          lba_byte(lba_q, hob_q, 2), lba_byte(lba_q, hob_q, 1),
          lba_byte(lba_q, hob_q, 0), hob_q ? cnt_q[15:8] : cnt_q[7:0]
        };
        srer_pkg::OFF_TASK: prdata <= {16'h0, err_q, status_q};
        srer_pkg::OFF_ELOG: prdata <= {24'h0, elog_q};
        srer_pkg::OFF_IRQ_ST: prdata <= {29'h0, irq_st_q};
        srer_pkg::OFF_IRQ_MSK: prdata <= {29'h0, irq_msk_q};
        srer_pkg::OFF_CFG: prdata <= {24'h0, dflt_q};
        default: pslverr <= 1'b1;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // srer_top
